// File: core/rcs_code_if.sv
/*
 * Carries the encoded ratio code from the encoder to the top.
 * Assumes both ends sit on the same clock.
 */
`timescale 1ns/10ps
interface rcs_code_if;
    logic [3:0] code;
    modport enc (output code);
    modport top (input code);
endinterface : rcs_code_if

// File: core/rcs_pkg.sv
/*
 * Shared constants for the ratio code signalling block.
 * Assumes a single 125 MHz clock.
 */
package rcs_pkg;
    localparam int          CLK_MHZ           = 125;
    localparam int          CODE_W            = 4;
    localparam int          DIV_W             = 4;
    localparam logic [3:0]  CODE_RST          = 4'hF;   // All lines released after reset
    localparam logic [3:0]  CODE_GE_12P5      = 4'h3;   // Shared code for 12.5x and above
    localparam logic [3:0]  CODE_11           = 4'h0;
    localparam logic [3:0]  CODE_BASE_5       = 4'h4;
    localparam logic [5:0]  HALF_5            = 6'h0A;  // Ratio 5 in half steps
    localparam logic [5:0]  HALF_10P5         = 6'h15;
    localparam logic [5:0]  HALF_11           = 6'h16;
    localparam logic [5:0]  HALF_12           = 6'h18;
    localparam logic [5:0]  HALF_12P5         = 6'h19;
    localparam logic [3:0]  HALT_DIV_RST      = 4'h0;
    localparam logic [3:0]  STPG_DIV_RST      = 4'h0;

    typedef enum logic [1:0] {
        RCS_IDLE  = 2'b00,
        RCS_WAIT  = 2'b01,
        RCS_VALID = 2'b10
    } rcs_state_t;
endpackage : rcs_pkg

// File: core/rcs_ratio_enc.sv
/*
 * Maps a ratio in half steps to the 4-bit ratio code.
 * Assumes the ratio input is a registered value.
 */
`timescale 1ns/10ps
module rcs_ratio_enc (
    input  wire logic [5:0] ratio_half,
    rcs_code_if.enc         code_if
);
    logic [5:0] off;

    // Table lookup, combinational
    always_comb begin
        off = 6'h00;
        if (ratio_half >= rcs_pkg::HALF_12P5) begin
            code_if.code = rcs_pkg::CODE_GE_12P5;
        end else if (ratio_half >= rcs_pkg::HALF_11) begin
            off = ratio_half - rcs_pkg::HALF_11;
            code_if.code = rcs_pkg::CODE_11 + off[3:0];
        end else if (ratio_half >= rcs_pkg::HALF_5) begin
            off = ratio_half - rcs_pkg::HALF_5;
            code_if.code = rcs_pkg::CODE_BASE_5 + off[3:0];
        end else begin
            code_if.code = rcs_pkg::CODE_BASE_5;                               // Below range clamps to 5x
        end
    end
endmodule : rcs_ratio_enc

// File: core/rcs_top.sv
/*
 * Ratio code signalling: reports the core clock ratio on open-drain lines once
 * power is good, and holds the fwd-clock reset, bus-attach and divisor settings.
 * The ratio arrives in half steps and is encoded by rcs_ratio_enc; the code is
 * captured once per power-up and then held, so the chipset may sample it at any
 * time while CODE_VALID stays high.
 * The forwarding reset and bus-attach pins are only synchronised and reported;
 * the forwarding logic itself sits outside this block.
 * Limitation: the code lines are never driven high; the high level the chipset sees
 * comes from the board pull-ups alone.
 * Assumes external pull-ups on the code lines and asynchronous pin inputs.
 * Assumes RATIO_HALF and the divisor write port come from logic on CLOCK, so
 * they are read without synchronisers.
 * Assumes software writes the divisors before it relies on the disconnect modes.
 */
// Function
// - Codes map ratios 5 to 12
// - Ratios from 12.5 share code 0011
// - Code lines only pull low
// - Code valid only after power good
// - Fwd-clock reset clears forwarding logic
// - Bus-attach used for power and init
// - Divisors come from software clock setting
`timescale 1ns/10ps
module rcs_top (
    input  wire logic       CLOCK,
    input  wire logic       ARST_N,
    input  wire logic [5:0] RATIO_HALF,
    input  wire logic       POWER_GOOD,
    input  wire logic       FWD_CLOCK_RESET,
    input  wire logic       BUS_ATTACH,
    input  wire logic       CLK_CTL_WE,
    input  wire logic [3:0] HALT_DIV_IN,
    input  wire logic [3:0] STPG_DIV_IN,
    input  wire logic [3:0] RATIO_CODE_IN,
    output logic      [3:0] RATIO_CODE_OUT,
    output logic      [3:0] RATIO_CODE_OE,
    output logic            CODE_VALID,
    output logic            FWD_RESET_ACTIVE,
    output logic            FWD_INIT_DONE,
    output logic            PM_ATTACHED,
    output logic      [3:0] HALT_DIV,
    output logic      [3:0] STPG_DIV
);
    rcs_code_if code_if ();

    // Pin synchronisers: two flip-flops per pin, only the second stage is read
    logic [1:0]             pg_sync_ff;
    logic [1:0]             fr_sync_ff;
    logic [1:0]             ba_sync_ff;
    // Captured ratio code and software divisor settings
    logic [3:0]             code_ff;
    logic [3:0]             halt_ff;
    logic [3:0]             stpg_ff;
    // Forwarding reset, forwarding init and bus-attach status
    logic                   fwd_rst_ff;
    logic                   fwd_init_ff;
    logic                   attach_ff;
    // Power-up sequencer and its decoded views; the decodes are shared so the
    // valid flag and the line enables can never disagree
    rcs_pkg::rcs_state_t    state_ff;
    rcs_pkg::rcs_state_t    nxt_state;
    logic                   pg_seen;
    logic                   code_drive;

    // Encoder is combinational; its output only matters at the capture edge,
    // so a ratio that settles late in the cycle costs nothing
    rcs_ratio_enc u_enc (
        .ratio_half (RATIO_HALF),
        .code_if    (code_if)
    );

    // Power good synchroniser; the pin may rise at any point of the clock cycle,
    // so the first stage may go metastable and is never read by logic
    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            pg_sync_ff <= 2'h0;
        end else begin
            pg_sync_ff <= {pg_sync_ff[0], POWER_GOOD};
        end
    end

    // Forwarding reset synchroniser; a pulse shorter than a clock cycle may be
    // missed, which is acceptable for a level held through reset
    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            fr_sync_ff <= 2'h0;
        end else begin
            fr_sync_ff <= {fr_sync_ff[0], FWD_CLOCK_RESET};
        end
    end

    // Bus-attach synchroniser; the system changes this pin slowly, so two stages
    // are enough and no filtering is done
    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            ba_sync_ff <= 2'h0;
        end else begin
            ba_sync_ff <= {ba_sync_ff[0], BUS_ATTACH};
        end
    end

    // Synchronised power good, shared by the sequencer and the init flag.
    // The readback pins carry the resolved wire level; nothing here needs it,
    // so they are left unread rather than synchronised for no consumer.
    assign pg_seen = pg_sync_ff[1];

    // Sequencing: code is only driven once power good is seen; the extra idle
    // state keeps the lines released for one cycle after reset whatever the pins do
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            rcs_pkg::RCS_IDLE: begin
                nxt_state = rcs_pkg::RCS_WAIT;
            end
            rcs_pkg::RCS_WAIT: begin
                if (pg_seen) nxt_state = rcs_pkg::RCS_VALID;
            end
            rcs_pkg::RCS_VALID: begin
                // Losing power good drops the code; the next rise captures afresh
                if (!pg_seen) nxt_state = rcs_pkg::RCS_WAIT;
            end
            default: begin
                nxt_state = rcs_pkg::RCS_IDLE;
            end
        endcase
    end

    // State register; the unused code falls back to idle through the default
    // branch above, so an upset can only release the lines, never pull them
    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            state_ff <= rcs_pkg::RCS_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Code latched once on entry to valid and held, so the chipset sees one value.
    // Ratio changes while valid are ignored: a moving code could have the chipset
    // build its init packet for a ratio the core is not running at.
    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            code_ff <= rcs_pkg::CODE_RST;
        end else if (state_ff == rcs_pkg::RCS_WAIT && pg_seen) begin
            code_ff <= code_if.code;
        end
    end

    // Open-drain drive: output level fixed low, so a line never fights its pull-up
    assign RATIO_CODE_OUT = 4'h0;
    assign code_drive     = (state_ff == rcs_pkg::RCS_VALID);
    assign CODE_VALID     = code_drive;

    // Per line: pull low only for a zero bit of the held code, release otherwise.
    // Enables are decoded from registers only, never from the pins directly.
    for (genvar i = 0; i < 4; i++) begin : g_line
        assign RATIO_CODE_OE[i] = code_drive & ~code_ff[i];
    end

    // Forwarding reset status follows the synchronised pin. It comes out of reset
    // active for one cycle only; the first edge loads the cleared second stage before the pin has been sampled.
    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            fwd_rst_ff <= 1'b1;
        end else begin
            fwd_rst_ff <= fr_sync_ff[1];
        end
    end

    // Forwarding init is done once bus-attach is seen with power good. The
    // forwarding reset clears it and wins over a set in the same cycle, since a
    // half-initialised forwarding path must never be reported as ready.
    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            fwd_init_ff <= 1'b0;
        end else if (fr_sync_ff[1]) begin
            fwd_init_ff <= 1'b0;
        end else if (ba_sync_ff[1] && pg_seen) begin
            fwd_init_ff <= 1'b1;
        end
    end

    // Bus-attach status for power management
    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            attach_ff <= 1'b0;
        end else begin
            attach_ff <= ba_sync_ff[1];
        end
    end

    // Halt disconnect divisor: written by software during start-up, applies to
    // every ratio code; no check of its range is made here
    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            halt_ff <= rcs_pkg::HALT_DIV_RST;
        end else if (CLK_CTL_WE) begin
            halt_ff <= HALT_DIV_IN;
        end
    end

    // Stop-grant disconnect divisor, written by the same strobe so the pair
    // always changes together
    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            stpg_ff <= rcs_pkg::STPG_DIV_RST;
        end else if (CLK_CTL_WE) begin
            stpg_ff <= STPG_DIV_IN;
        end
    end

    // Registered status straight to the ports; no logic sits between the
    // flip-flops and the pins, so the outputs change only on the clock edge or when ARST_N falls
    assign FWD_RESET_ACTIVE = fwd_rst_ff;
    assign FWD_INIT_DONE    = fwd_init_ff;
    assign PM_ATTACHED      = attach_ff;
    assign HALT_DIV         = halt_ff;
    assign STPG_DIV         = stpg_ff;
endmodule : rcs_top

// File: tb/rcs_chipset_model.sv
/* Chipset side model: samples the pulled-up code lines once.
   Assumes code_wire is the resolved open-drain level. */
`timescale 1ns/10ps
module rcs_chipset_model (
    input  wire logic       clk,
    input  wire logic       power_good,
    input  wire logic [3:0] code_wire,
    output logic      [3:0] pkt_code_ff
);
    logic [3:0] wait_ff;
    // Waits eight edges past power good so the lines have settled; one capture per power-up
    always_ff @(posedge clk) begin
        if (!power_good) wait_ff <= 4'h0;
        else if (wait_ff != 4'h8) wait_ff <= wait_ff + 4'h1;
        if (power_good && wait_ff == 4'h7) pkt_code_ff <= code_wire;
    end
endmodule : rcs_chipset_model

// File: tb/rcs_top_bench.sv
/* Bench for rcs_top: ratio codes, reset inputs, divisor writes.
   Assumes pull-ups on the code lines, modelled here. */
`timescale 1ns/10ps
module rcs_top_bench;
    logic       clk = 1'b0, arst_n = 1'b0, pg = 1'b0, fwd = 1'b0, att = 1'b0, we = 1'b0;
    logic [5:0] half = 6'h0A;
    logic [3:0] hdiv = 4'h0, sdiv = 4'h0, oe, out, hd, sd, pkt, exp, lvl;
    logic       cv, fra, fid, pma;
    int         error_cnt = 0, cmp_count = 0, cyc = 0;
    // Pull-up wins unless the device pulls the line low
    assign lvl = ~oe;
    rcs_top dut (.CLOCK(clk), .ARST_N(arst_n), .RATIO_HALF(half), .POWER_GOOD(pg), .FWD_CLOCK_RESET(fwd),
        .BUS_ATTACH(att), .CLK_CTL_WE(we), .HALT_DIV_IN(hdiv), .STPG_DIV_IN(sdiv), .RATIO_CODE_IN(lvl),
        .RATIO_CODE_OUT(out), .RATIO_CODE_OE(oe), .CODE_VALID(cv), .FWD_RESET_ACTIVE(fra),
        .FWD_INIT_DONE(fid), .PM_ATTACHED(pma), .HALT_DIV(hd), .STPG_DIV(sd));
    rcs_chipset_model u_cs (.clk(clk), .power_good(pg), .code_wire(lvl), .pkt_code_ff(pkt));
    initial forever #4 clk = ~clk;
    task automatic check(input logic [5:0] seen, input logic [5:0] want);
        cmp_count++;
        if (seen !== want) begin
            error_cnt++;
            $display("BAD t=%0t seen=%0h exp=%0h", $time, seen, want);
        end
    endtask : check
    task automatic stop_test;
        $display("compares=%0d mismatches=%0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : stop_test
    // Cuts a hang short well past the expected few hundred cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 1000) begin
            error_cnt++;
            stop_test();
        end
    end
    // Inputs move on the falling edge only
    initial begin
        repeat (4) @(negedge clk);
        arst_n = 1'b1;
        check(cv, 1'b0);
        check(fra, 1'b1);
        check(hd, 4'h0);
        for (int h = 9; h < 28; h++) begin
            half = 6'(h);
            exp = h < 10 ? 4'h4 : (h < 22 ? 4'(h - 6) : (h < 25 ? 4'(h - 22) : 4'h3));
            pg = 1'b1;
            repeat (2) @(negedge clk);
            check(cv, 1'b0);
            repeat (10) @(negedge clk);
            half = 6'h0A;
            check(lvl, exp);
            check(out, 4'h0);
            check(pkt, exp);
            @(negedge clk);
            check(lvl, exp);
            pg = 1'b0;
            repeat (5) @(negedge clk);
            check(oe, 4'h0);
            $display("ratio step %0d done", h);
        end
        fwd = 1'b1;
        att = 1'b1;
        pg = 1'b1;
        repeat (5) @(negedge clk);
        check(fra, 1'b1);
        check(pma, 1'b1);
        check(fid, 1'b0);
        fwd = 1'b0;
        hdiv = 4'hA;
        sdiv = 4'h5;
        we = 1'b1;
        @(negedge clk);
        we = 1'b0;
        hdiv = 4'h3;
        repeat (5) @(negedge clk);
        check(fra, 1'b0);
        check(fid, 1'b1);
        check(hd, 4'hA);
        check(sd, 4'h5);
        $display("control inputs done");
        // Mid-run reset with power good still high: code must drop, then return
        arst_n = 1'b0;
        @(negedge clk);
        check(oe, 4'h0);
        check(fra, 1'b1);
        check(hd, 4'h0);
        arst_n = 1'b1;
        repeat (2) @(negedge clk);
        check(cv, 1'b0);
        check(fra, 1'b0);
        check(fid, 1'b0);
        repeat (2) @(negedge clk);
        check(cv, 1'b1);
        check(lvl, 4'h4);
        check(fid, 1'b1);
        $display("mid-run reset done");
        stop_test();
    end
endmodule : rcs_top_bench

// File: tb/rcs_top_sva.sv
/* Port checker for rcs_top.
   Assumes the bind below reaches every rcs_top instance. */
`timescale 1ns/10ps
module rcs_top_sva (
    input wire logic       CLOCK,
    input wire logic       ARST_N,
    input wire logic [5:0] RATIO_HALF,
    input wire logic       POWER_GOOD,
    input wire logic       FWD_CLOCK_RESET,
    input wire logic       BUS_ATTACH,
    input wire logic       CLK_CTL_WE,
    input wire logic [3:0] HALT_DIV_IN,
    input wire logic [3:0] STPG_DIV_IN,
    input wire logic [3:0] RATIO_CODE_OUT,
    input wire logic [3:0] RATIO_CODE_OE,
    input wire logic       CODE_VALID,
    input wire logic       FWD_RESET_ACTIVE,
    input wire logic       FWD_INIT_DONE,
    input wire logic       PM_ATTACHED,
    input wire logic [3:0] HALT_DIV,
    input wire logic [3:0] STPG_DIV
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!ARST_N);
    sequence s_pg_up; $rose(POWER_GOOD); endsequence
    sequence s_code_up; $rose(CODE_VALID); endsequence
    chk_pull_only: assert property (RATIO_CODE_OUT == 4'h0) else $error("code data not low");
    chk_idle_released: assert property (!CODE_VALID |-> RATIO_CODE_OE == 4'h0) else $error("pulled when invalid");
    chk_valid_latency: assert property (s_pg_up |-> ##[3:4] CODE_VALID) else $error("code late");
    chk_no_early: assert property (!POWER_GOOD [*4] |-> !CODE_VALID) else $error("valid without power");
    chk_code_low: assert property (s_code_up and RATIO_HALF <= 6'h15 |->
        ~RATIO_CODE_OE == (RATIO_HALF < 6'h0A ? 4'h4 : 4'(RATIO_HALF - 6'h06))) else $error("low ratio code wrong");
    chk_code_high: assert property (s_code_up and RATIO_HALF >= 6'h16 |->
        ~RATIO_CODE_OE == (RATIO_HALF > 6'h18 ? 4'h3 : 4'(RATIO_HALF - 6'h16))) else $error("high ratio code wrong");
    chk_code_hold: assert property (CODE_VALID && $past(CODE_VALID) |-> $stable(RATIO_CODE_OE)) else $error("code moved");
    chk_fwd_reset: assert property (FWD_CLOCK_RESET [*4] |-> FWD_RESET_ACTIVE) else $error("fwd reset missed");
    chk_init_clear: assert property (FWD_RESET_ACTIVE |-> !FWD_INIT_DONE) else $error("init done in fwd reset");
    chk_attach_seen: assert property (BUS_ATTACH [*4] |-> PM_ATTACHED) else $error("attach missed");
    chk_div_load: assert property (CLK_CTL_WE |=> HALT_DIV == $past(HALT_DIV_IN) && STPG_DIV == $past(STPG_DIV_IN))
        else $error("divisor not loaded");
    chk_div_keep: assert property (!CLK_CTL_WE |=> $stable(HALT_DIV) && $stable(STPG_DIV)) else $error("divisor moved");
endmodule : rcs_top_sva
bind rcs_top rcs_top_sva u_sva (.*);
